// file: core/idma_addr_gen.sv
// Purpose: Data memory address generation with pointers and indirect ports.
// Assumes: Requests are synchronous to clk_in; RAM and SFR reads are
//          combinational within the cycle their enable is high.
// Notes:   Access is taken at edge 1, memory strobe in cycle 1, read data
//          in cycle 2.
// What this block does
// - Indirect port accesses go to the location its pointer addresses.
// - Indirect port zero with pointer zero reaches sector 0 only.
// - Ports one and two: pointer high byte picks sector, low byte address.
// - Indirect ports store nothing; as registers they read 00H, ignore writes.
// - The five pointers are real registers, read and written like any other.
// - Extended direct accesses reach every sector; in sector 0 the port addresses still go through their pointers.
// - Extended address: upper bit is sector, low byte the address.
// - In sector 0 00H-7FH are special registers (other sectors read 00H there); in each sector 80H-FFH general RAM.
// - Unused special addresses in sector 0 get an SFR strobe and read what the SFR array returns.
`timescale 1ns/100ps
module idma_addr_gen #(
	parameter int NUM_SECT = 2,
	parameter int SECT_W   = 1
) (
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              acc_valid_in,
	input  wire logic              acc_write_in,
	input  wire logic              acc_ext_in,
	input  wire logic [8:0]        acc_addr_in,
	input  wire logic [7:0]        acc_wdata_in,
	output logic                   rd_valid_out,
	output logic [7:0]             rd_data_out,
	output logic                   ram_en_out,
	output logic                   ram_we_out,
	output logic [SECT_W+6:0]      ram_addr_out,
	output logic [7:0]             ram_wdata_out,
	input  wire logic [7:0]        ram_rdata_in,
	output logic                   sfr_en_out,
	output logic                   sfr_we_out,
	output logic [6:0]             sfr_addr_out,
	output logic [7:0]             sfr_wdata_out,
	input  wire logic [7:0]        sfr_rdata_in
);
	typedef struct packed {
		logic [7:0]        ptr0;
		logic [7:0]        ptr1_lo;
		logic [7:0]        ptr1_sc;
		logic [7:0]        ptr2_lo;
		logic [7:0]        ptr2_sc;
		logic              ram_en;
		logic              sfr_en;
		logic              we;
		logic [SECT_W+6:0] maddr;
		logic [7:0]        wdata;
		logic              rd_pend;
		logic [1:0]        kind;
		logic [7:0]        ldata;
		logic              rd_valid;
		logic [7:0]        rd_data;
	} idma_state_t;

	localparam logic [7:0] ZERO_BYTE_C = idma_pkg::ZERO_BYTE;

	idma_state_t st;
	idma_state_t next_st;

	always_comb begin
		logic [7:0] sect;
		logic [7:0] addr;
		logic [1:0] kind;
		sect = ZERO_BYTE_C;
		addr = ZERO_BYTE_C;
		kind = idma_pkg::KIND_ZERO;
		next_st = st;
		next_st.ram_en = 1'b0;
		next_st.sfr_en = 1'b0;
		next_st.rd_pend = 1'b0;
		next_st.rd_valid = 1'b0;
		// Second stage: pick up the data of the strobe that went out at the last edge and is high this cycle.
		if (st.rd_pend) begin
			next_st.rd_valid = 1'b1;
			case (st.kind)
				idma_pkg::KIND_RAM: next_st.rd_data = ram_rdata_in;
				idma_pkg::KIND_SFR: next_st.rd_data = sfr_rdata_in;
				idma_pkg::KIND_PTR: next_st.rd_data = st.ldata;
				default:            next_st.rd_data = ZERO_BYTE_C;
			endcase
		end
		// Standard instructions see sector 0 only; extended ones carry the
		// sector in the ninth bit.
		if (acc_ext_in) begin
			sect = {7'h00, acc_addr_in[8]};
		end
		addr = acc_addr_in[7:0];
		if (sect == ZERO_BYTE_C) begin
			case (addr)
				idma_pkg::ADDR_IND_ZERO: begin
					sect = ZERO_BYTE_C;
					addr = st.ptr0;
				end
				idma_pkg::ADDR_IND_ONE: begin
					sect = st.ptr1_sc;
					addr = st.ptr1_lo;
				end
				idma_pkg::ADDR_IND_TWO: begin
					sect = st.ptr2_sc;
					addr = st.ptr2_lo;
				end
				default: addr = acc_addr_in[7:0];
			endcase
		end
		// A pointer that names an indirect port again lands on the port as a
		// plain register, so there is no chained indirection to resolve.
		if (sect >= 8'(NUM_SECT)) begin
			kind = idma_pkg::KIND_ZERO;
		end else if (addr[idma_pkg::GP_BIT]) begin
			kind = idma_pkg::KIND_RAM;
		end else if (sect != ZERO_BYTE_C) begin
			kind = idma_pkg::KIND_ZERO;
		end else begin
			case (addr)
				idma_pkg::ADDR_IND_ZERO,
				idma_pkg::ADDR_IND_ONE,
				idma_pkg::ADDR_IND_TWO:    kind = idma_pkg::KIND_ZERO;
				idma_pkg::ADDR_PTR_ZERO,
				idma_pkg::ADDR_PTR_ONE_LO,
				idma_pkg::ADDR_PTR_ONE_SC,
				idma_pkg::ADDR_PTR_TWO_LO,
				idma_pkg::ADDR_PTR_TWO_SC: kind = idma_pkg::KIND_PTR;
				default:                   kind = idma_pkg::KIND_SFR;
			endcase
		end
		if (acc_valid_in) begin
			next_st.kind = kind;
			next_st.we = acc_write_in;
			next_st.maddr = {sect[SECT_W-1:0], addr[6:0]};
			next_st.wdata = acc_wdata_in;
			next_st.ram_en = (kind == idma_pkg::KIND_RAM);
			next_st.sfr_en = (kind == idma_pkg::KIND_SFR);
			next_st.rd_pend = !acc_write_in;
			case (addr)
				idma_pkg::ADDR_PTR_ZERO:   next_st.ldata = st.ptr0;
				idma_pkg::ADDR_PTR_ONE_LO: next_st.ldata = st.ptr1_lo;
				idma_pkg::ADDR_PTR_ONE_SC: next_st.ldata = st.ptr1_sc;
				idma_pkg::ADDR_PTR_TWO_LO: next_st.ldata = st.ptr2_lo;
				idma_pkg::ADDR_PTR_TWO_SC: next_st.ldata = st.ptr2_sc;
				default:                   next_st.ldata = ZERO_BYTE_C;
			endcase
			// A write that lands on a pointer, directly or through a port,
			// updates it, and the very next request already sees the value.
			if (acc_write_in && kind == idma_pkg::KIND_PTR) begin
				case (addr)
					idma_pkg::ADDR_PTR_ZERO:   next_st.ptr0 = acc_wdata_in;
					idma_pkg::ADDR_PTR_ONE_LO: next_st.ptr1_lo = acc_wdata_in;
					idma_pkg::ADDR_PTR_ONE_SC: next_st.ptr1_sc = acc_wdata_in;
					idma_pkg::ADDR_PTR_TWO_LO: next_st.ptr2_lo = acc_wdata_in;
					idma_pkg::ADDR_PTR_TWO_SC: next_st.ptr2_sc = acc_wdata_in;
					default:                   next_st.ptr0 = st.ptr0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.ptr0 <= idma_pkg::PTR_RESET;
			st.ptr1_lo <= idma_pkg::PTR_RESET;
			st.ptr1_sc <= idma_pkg::PTR_RESET;
			st.ptr2_lo <= idma_pkg::PTR_RESET;
			st.ptr2_sc <= idma_pkg::PTR_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rd_valid_out  = st.rd_valid;
	assign rd_data_out   = st.rd_data;
	assign ram_en_out    = st.ram_en;
	assign ram_we_out    = st.ram_en & st.we;
	assign ram_addr_out  = st.maddr;
	assign ram_wdata_out = st.wdata;
	assign sfr_en_out    = st.sfr_en;
	assign sfr_we_out    = st.sfr_en & st.we;
	assign sfr_addr_out  = st.maddr[6:0];
	assign sfr_wdata_out = st.wdata;

	default clocking dcb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Standard requests see sector 0 only, so the port mappings are checked
	// on them; extended requests have decode checks of their own.
	wire std_req = acc_valid_in && !acc_ext_in;

	ind_zero_map_a: assert property (
		std_req && acc_addr_in[7:0] == idma_pkg::ADDR_IND_ZERO && st.ptr0[7]
		|=> ram_en_out
		&& ram_addr_out == {{SECT_W{1'b0}}, $past(st.ptr0[6:0])})
		else $error("indirect port zero did not follow pointer zero");

	ind_one_map_a: assert property (
		std_req && acc_addr_in[7:0] == idma_pkg::ADDR_IND_ONE
		&& st.ptr1_lo[7] && st.ptr1_sc < 8'(NUM_SECT)
		|=> ram_en_out && ram_addr_out
		== {$past(st.ptr1_sc[SECT_W-1:0]), $past(st.ptr1_lo[6:0])})
		else $error("indirect port one mapped to the wrong location");

	ind_two_map_a: assert property (
		std_req && acc_addr_in[7:0] == idma_pkg::ADDR_IND_TWO
		&& st.ptr2_lo[7] && st.ptr2_sc < 8'(NUM_SECT)
		|=> ram_en_out && ram_addr_out
		== {$past(st.ptr2_sc[SECT_W-1:0]), $past(st.ptr2_lo[6:0])})
		else $error("indirect port two mapped to the wrong location");

	// A pointer that names its own port lands on the port as a register.
	port_read_zero_a: assert property (
		std_req && !acc_write_in && st.ptr0 == idma_pkg::ADDR_IND_ZERO
		&& acc_addr_in[7:0] == idma_pkg::ADDR_IND_ZERO
		|=> !ram_en_out && !sfr_en_out
		##1 rd_valid_out && rd_data_out == 8'h00)
		else $error("indirect port read as a register was not zero");

	port_write_nop_a: assert property (
		std_req && acc_write_in && acc_addr_in[7:0] == idma_pkg::ADDR_IND_TWO
		&& st.ptr2_sc == 8'h00 && st.ptr2_lo == idma_pkg::ADDR_IND_TWO
		|=> !ram_en_out && !sfr_en_out
		&& $stable(st.ptr2_lo) && $stable(st.ptr2_sc))
		else $error("write to an indirect port as a register had an effect");

	ptr_write_a: assert property (
		std_req && acc_write_in && acc_addr_in[7:0] == idma_pkg::ADDR_PTR_ZERO
		|=> st.ptr0 == $past(acc_wdata_in) && !ram_en_out)
		else $error("pointer zero write not stored");

	ptr_sector_write_a: assert property (
		std_req && acc_write_in
		&& acc_addr_in[7:0] == idma_pkg::ADDR_PTR_ONE_SC
		|=> st.ptr1_sc == $past(acc_wdata_in) && !ram_en_out && !sfr_en_out)
		else $error("pointer one sector write not stored");

	ptr_read_a: assert property (
		std_req && !acc_write_in
		&& acc_addr_in[7:0] == idma_pkg::ADDR_PTR_TWO_SC
		|-> ##2 rd_valid_out && rd_data_out == $past(st.ptr2_sc, 2))
		else $error("pointer read returned the wrong value");

	ext_decode_a: assert property (
		acc_valid_in && acc_ext_in && acc_addr_in[7]
		|=> ram_en_out && ram_addr_out
		== {SECT_W'($past(acc_addr_in[8])), $past(acc_addr_in[6:0])})
		else $error("extended address decoded wrongly");

	ext_ram_write_a: assert property (
		acc_valid_in && acc_write_in && acc_ext_in && acc_addr_in[7]
		|=> ram_we_out && ram_wdata_out == $past(acc_wdata_in))
		else $error("extended write did not reach general RAM");

	// Extended requests to sector 1 never go through a pointer, even at a port address.
	ext_no_ptr_a: assert property (
		acc_valid_in && acc_ext_in && acc_addr_in[8]
		&& acc_addr_in[7:0] == idma_pkg::ADDR_IND_ONE
		|=> !ram_en_out && !sfr_en_out)
		else $error("extended access to sector one used a pointer");

	// Port addresses are left out: they may legally reach general RAM.
	special_split_a: assert property (
		acc_valid_in && !acc_addr_in[7]
		&& acc_addr_in[7:0] != idma_pkg::ADDR_IND_ZERO
		&& acc_addr_in[7:0] != idma_pkg::ADDR_IND_ONE
		&& acc_addr_in[7:0] != idma_pkg::ADDR_IND_TWO |=> !ram_en_out)
		else $error("special address reached general RAM");

	sfr_strobe_a: assert property (
		std_req && acc_addr_in[7:4] != 4'h0 && !acc_addr_in[7]
		|=> sfr_en_out && sfr_addr_out == $past(acc_addr_in[6:0]))
		else $error("special address did not reach the special registers");

	unused_zero_a: assert property (
		acc_valid_in && acc_ext_in && !acc_write_in && acc_addr_in[8]
		&& !acc_addr_in[7]
		|-> ##2 rd_valid_out && rd_data_out == 8'h00)
		else $error("unused special address did not read zero");

	bad_sector_a: assert property (
		std_req && acc_addr_in[7:0] == idma_pkg::ADDR_IND_ONE
		&& st.ptr1_sc >= 8'(NUM_SECT)
		|=> !ram_en_out && !sfr_en_out)
		else $error("missing sector was accessed");

	write_no_answer_a: assert property (
		acc_valid_in && acc_write_in |-> ##2 !rd_valid_out)
		else $error("a write produced read data");

	read_data_hold_a: assert property (
		!st.rd_pend |=> $stable(rd_data_out))
		else $error("read data changed without a read");

	ind_ram_c: cover property (
		std_req && acc_addr_in[7:0] == idma_pkg::ADDR_IND_TWO ##1 ram_en_out);
	ext_read_c: cover property (
		acc_valid_in && acc_ext_in && !acc_write_in ##2 rd_valid_out);
	sfr_write_c: cover property (sfr_en_out && sfr_we_out);
	ptr_write_c: cover property (
		std_req && acc_write_in
		&& acc_addr_in[7:0] == idma_pkg::ADDR_PTR_ONE_SC);
	bad_sector_c: cover property (
		std_req && acc_addr_in[7:0] == idma_pkg::ADDR_IND_ONE
		&& st.ptr1_sc >= 8'(NUM_SECT));
endmodule : idma_addr_gen

// file: core/idma_pkg.sv
// Purpose: Shared constants for the indirect data memory address generator.
// Assumes: 8-bit data memory, sectors of 256 bytes, one core clock.
// Notes:   Offsets are byte addresses inside sector 0.
package idma_pkg;
	localparam logic [7:0] ADDR_IND_ZERO   = 8'h00;
	localparam logic [7:0] ADDR_PTR_ZERO   = 8'h01;
	localparam logic [7:0] ADDR_IND_ONE    = 8'h02;
	localparam logic [7:0] ADDR_PTR_ONE_LO = 8'h03;
	localparam logic [7:0] ADDR_PTR_ONE_SC = 8'h04;
	localparam logic [7:0] ADDR_IND_TWO    = 8'h0C;
	localparam logic [7:0] ADDR_PTR_TWO_LO = 8'h0D;
	localparam logic [7:0] ADDR_PTR_TWO_SC = 8'h0E;
	// Bit 7 of the in-sector address splits special from general space.
	localparam int         GP_BIT          = 7;
	localparam logic [7:0] PTR_RESET       = 8'h00;
	localparam logic [7:0] ZERO_BYTE       = 8'h00;
	// Kind of target that an accepted access resolved to.
	localparam logic [1:0] KIND_ZERO       = 2'h0;
	localparam logic [1:0] KIND_RAM        = 2'h1;
	localparam logic [1:0] KIND_SFR        = 2'h2;
	localparam logic [1:0] KIND_PTR        = 2'h3;
endpackage : idma_pkg

// file: verification/idma_mem_model.sv
// Purpose: Behavioural RAM and special register array behind the block.
// Assumes: Reads are combinational while the strobe is high.
// Notes:   A deselected read port shows a changing pattern, never old data.
`timescale 1ns/100ps
module idma_mem_model (
	input  wire logic       clk_in,
	input  wire logic       ram_en_in,
	input  wire logic       ram_we_in,
	input  wire logic [7:0] ram_addr_in,
	input  wire logic [7:0] ram_wdata_in,
	output logic      [7:0] ram_rdata_out,
	input  wire logic       sfr_en_in,
	input  wire logic       sfr_we_in,
	input  wire logic [6:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	output logic      [7:0] sfr_rdata_out
);
	logic [7:0] ram [0:255];
	logic [7:0] sfr [0:127];
	logic [7:0] junk = 8'h5A;
	// Every special cell starts at zero, so unused ones read 00H.
	initial begin
		foreach (ram[i]) ram[i] = 8'h00;
		foreach (sfr[i]) sfr[i] = 8'h00;
	end
	always @(posedge clk_in) begin
		junk <= ~junk + 8'h01;
		if (ram_en_in && ram_we_in) ram[ram_addr_in] <= ram_wdata_in;
		if (sfr_en_in && sfr_we_in) sfr[sfr_addr_in] <= sfr_wdata_in;
	end
	assign ram_rdata_out = ram_en_in ? ram[ram_addr_in] : junk;
	assign sfr_rdata_out = sfr_en_in ? sfr[sfr_addr_in] : ~junk;
endmodule : idma_mem_model

// file: verification/tb_idma_addr_gen.sv
// Purpose: Self-checking bench for the address generator.
// Assumes: Inputs change at the falling edge; reads answer two edges later.
// Notes:   A reference model with arrays predicts every read.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_idma_addr_gen;
	logic clk_in = 0, rst_n_in = 0, acc_valid_in = 0, acc_write_in = 0;
	logic acc_ext_in = 0, rd_valid_out, ram_en_out, ram_we_out;
	logic sfr_en_out, sfr_we_out;
	logic [8:0] acc_addr_in = 9'h000;
	logic [7:0] acc_wdata_in = 8'h00, rd_data_out, ram_addr_out;
	logic [7:0] ram_wdata_out, ram_rdata_in, sfr_wdata_out, sfr_rdata_in;
	logic [6:0] sfr_addr_out;
	logic [7:0] m_ram [0:255], m_sfr [0:127], p [0:4];
	logic [31:0] seed = 32'h74ce_1478;
	int fails = 0, samples_checked = 0;
	always #20 clk_in = ~clk_in;
	idma_addr_gen idma_addr_gen_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.acc_valid_in(acc_valid_in), .acc_write_in(acc_write_in),
		.acc_ext_in(acc_ext_in), .acc_addr_in(acc_addr_in),
		.acc_wdata_in(acc_wdata_in), .rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out), .ram_en_out(ram_en_out),
		.ram_we_out(ram_we_out), .ram_addr_out(ram_addr_out),
		.ram_wdata_out(ram_wdata_out), .ram_rdata_in(ram_rdata_in),
		.sfr_en_out(sfr_en_out), .sfr_we_out(sfr_we_out),
		.sfr_addr_out(sfr_addr_out), .sfr_wdata_out(sfr_wdata_out),
		.sfr_rdata_in(sfr_rdata_in));
	idma_mem_model idma_mem_model_inst (.clk_in(clk_in),
		.ram_en_in(ram_en_out), .ram_we_in(ram_we_out),
		.ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out),
		.ram_rdata_out(ram_rdata_in), .sfr_en_in(sfr_en_out),
		.sfr_we_in(sfr_we_out), .sfr_addr_in(sfr_addr_out),
		.sfr_wdata_in(sfr_wdata_out), .sfr_rdata_out(sfr_rdata_in));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Target code: -1 reads zero, below 256 RAM, 256+k pointer k, else SFR.
	function automatic int tgt(input logic [7:0] sc, input logic [7:0] o);
		if (sc > 8'h01) return -1;
		if (o[7]) return {sc[0], o[6:0]};
		if (sc != 8'h00) return -1;
		case (o)
			8'h01: return 256;
			8'h03: return 257;
			8'h04: return 258;
			8'h0D: return 259;
			8'h0E: return 260;
			8'h00, 8'h02, 8'h0C: return -1;
			default: return 512 + o;
		endcase
	endfunction : tgt
	task automatic acc(input logic w, input logic e, input logic [8:0] a,
		input logic [7:0] d);
		logic [7:0] sc, o, x;
		int t;
		sc = e ? {7'h00, a[8]} : 8'h00;
		o = a[7:0];
		if (sc == 8'h00 && o == 8'h00) o = p[0];
		else if (sc == 8'h00 && o == 8'h02) begin
			sc = p[2];
			o = p[1];
		end else if (sc == 8'h00 && o == 8'h0C) begin
			sc = p[4];
			o = p[3];
		end
		t = tgt(sc, o);
		x = t < 0 ? 8'h00 : t < 256 ? m_ram[t] : t < 512 ? p[t-256] : m_sfr[t-512];
		if (w && t >= 0) begin
			if (t < 256) m_ram[t] = d;
			else if (t < 512) p[t-256] = d;
			else m_sfr[t-512] = d;
		end
		acc_valid_in = 1;
		acc_write_in = w;
		acc_ext_in = e;
		acc_addr_in = a;
		acc_wdata_in = d;
		@(negedge clk_in);
		`CHK("rd_early", 1'b0, rd_valid_out)
		`CHK("ram_en", t >= 0 && t < 256, ram_en_out)
		`CHK("ram_we", w && t >= 0 && t < 256, ram_we_out)
		`CHK("sfr_en", t >= 512, sfr_en_out)
		`CHK("sfr_we", w && t >= 512, sfr_we_out)
		if (!w) begin
			acc_valid_in = 0;
			@(negedge clk_in);
			`CHK("rd_valid", 1'b1, rd_valid_out)
			`CHK("rd_data", x, rd_data_out)
		end
	endtask : acc
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	initial begin
		repeat (40000) @(posedge clk_in);
		fails++;
		complete_run();
	end
	initial begin
		logic [8:0] a;
		logic [7:0] d;
		foreach (m_ram[i]) m_ram[i] = 8'h00;
		foreach (m_sfr[i]) m_sfr[i] = 8'h00;
		foreach (p[i]) p[i] = 8'h00;
		repeat (20) @(negedge clk_in);
		rst_n_in = 1;
		acc(0, 0, 9'h001, 8'h00);
		acc(1, 1, 9'h1F0, 8'hAB);
		acc(1, 0, 9'h004, 8'h01);
		acc(1, 0, 9'h003, 8'hF0);
		acc(0, 0, 9'h002, 8'h00);
		$display("test directed done");
		for (int i = 0; i < 1500; i++) begin
			seed = xs(seed);
			a = seed[2] ? seed[16:8] : {5'h00, seed[12:9]};
			d = (a[3:0] == 4'h4 || a[3:0] == 4'hE) ? {6'h00, seed[31:30]}
				: seed[31:24];
			acc(seed[0], seed[1], a, d);
		end
		acc_valid_in = 0;
		$display("test random done");
		complete_run();
	end
endmodule : tb_idma_addr_gen
